/* File: pkg/dsr_pkg.sv */
package dsr_pkg;
	// Register offsets of the readback bank
	localparam logic [2:0] OFS_CHANNEL_ON = 3'h0;
	localparam logic [2:0] OFS_OC_MASK = 3'h1;
	localparam logic [2:0] OFS_OPEN_MASK = 3'h2;
	localparam logic [2:0] OFS_CONFIG = 3'h3;
	localparam logic [2:0] OFS_STATUS = 3'h4;
	localparam logic [2:0] OFS_OPEN_FLAGS = 3'h5;
	// Configuration field positions
	localparam int CFG_FRAME_CHECK = 3;
	localparam int CFG_RETRY = 4;
	localparam int CFG_PAIRING = 5;
	localparam int CFG_LONG_DEGLITCH = 6;
	localparam int CFG_FORCE_FAULT = 7;
	localparam logic [7:0] CFG_RSVD_MASK = 8'hF8;
	// Status field positions
	localparam int ST_POWER_ON = 0;
	localparam int ST_LOCK = 1;
	localparam int ST_THERMAL = 2;
	localparam int ST_ANY_OC = 4;
	localparam int ST_ANY_OPEN = 5;
	localparam int ST_FRAME_ERR = 6;
	localparam int ST_FAULT = 7;
	// Reset values
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic RST_POWER_ON = 1'b1;
	localparam logic RST_FAULT = 1'b1;
	// Timing in nanoseconds; clock period 4 ns
	localparam int CLK_PERIOD_NS = 4;
	localparam int RETRY_NS = 100000000;
	localparam int DEGLITCH_SHORT_NS = 3500;
	localparam int DEGLITCH_LONG_NS = 10000;
	localparam int RETRY_CYC = RETRY_NS / CLK_PERIOD_NS;
	localparam int DGL_SHORT_CYC =
		(DEGLITCH_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DGL_LONG_CYC =
		(DEGLITCH_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Write-side values as seen by the bank
	typedef struct packed {
		logic [7:0] channel_on_bit;
		logic [7:0] overcurrent_mask_bit;
		logic [7:0] open_mask_bit;
		logic [7:0] config_bits;
	} dsr_ctrl_t;
	// Clear commands from the frame decoder
	typedef struct packed {
		logic clear_all_faults_cmd;
		logic clear_thermal_cmd;
		logic clear_power_on_cmd;
	} dsr_cmd_t;
endpackage : dsr_pkg

/* File: logic/dsr_bank.sv */
// Behaviour
// - Overtemperature sets flag, forces all channels off
// - Outputs resume commanded state once cooled
// - Thermal flag held until clear commands
// - Offset 0 reads channel on bits
// - Offset 1 reads over-current mask bits
// - Offset 2 reads open-load mask bits
// - Config bit 3 frame check, 2:0 zero
// - Config bit 4 over-current retry after 100ms
// - Config bit 5 pairs pulse inputs
// - Config bit 6 picks 3.5us or 10us deglitch
// - Config bit 7 forces fault output low
// - Status bit 0 power-on, resets to one
// - Status bit 1 shows write lock
// - Status bit 2 thermal, bit 3 zero
// - Status bit 4 ORs over-current flags
// - Status bit 5 ORs open flags
// - Status bit 6 frame check failure
// - Status bit 7 summary fault, resets one
// - Offset 5 per-channel open flags
// - Live faults pull fault output low, frame error only with frame check
`timescale 1ns/1ps
`default_nettype none
module dsr_bank
	import dsr_pkg::*;
#(
	parameter int RETRY_CYCLES = RETRY_CYC
)
(
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire dsr_ctrl_t CTRL_I,
	input wire dsr_cmd_t CMD_I,
	input wire logic WRITE_LOCK_I,
	input wire logic FRAME_ERROR_I,
	input wire logic [2:0] RD_ADDR_I,
	input wire logic RD_EN_I,
	input wire logic OVER_TEMP_I,
	input wire logic [7:0] OVERCURRENT_I,
	input wire logic [7:0] OPEN_DETECT_I,
	input wire logic [3:0] PULSE_INPUT_N_I,
	output logic [7:0] RD_DATA_O,
	output logic [7:0] CHANNEL_DRIVE_O,
	output logic FAULT_ALARM_OUT_N_O,
	output logic FAULT_ALARM_OE_O
);

	////////////////////////////////////////////////////////////////////////
	logic [1:0] sync_temp;
	logic [7:0] sync_oc [2];
	logic [7:0] sync_open [2];
	logic [3:0] sync_pulse [2];
	logic thermal_shutdown_indicator;
	logic power_on;
	logic fault_latched;
	logic [7:0] oc_flag;
	logic [7:0] channel_open_indicator;
	logic [11:0] oc_count [8];
	logic [25:0] retry_count;
	logic retry_tick;
	logic [7:0] cfg;
	logic any_overcurrent_indicator;
	logic any_open;
	logic fault_now;
	logic [7:0] next_drive;
	logic [7:0] pulse_map;
	logic [11:0] deglitch_len;
	logic [7:0] rd_byte;

	assign cfg = CTRL_I.config_bits & CFG_RSVD_MASK;

	// Two-stage synchronisers for analog and pin inputs
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			sync_temp <= 2'h0;
			sync_oc[0] <= RST_BYTE;
			sync_oc[1] <= RST_BYTE;
			sync_open[0] <= RST_BYTE;
			sync_open[1] <= RST_BYTE;
			sync_pulse[0] <= 4'hF;
			sync_pulse[1] <= 4'hF;
		end
		else
		begin
			sync_temp <= {sync_temp[0], OVER_TEMP_I};
			sync_oc[0] <= OVERCURRENT_I;
			sync_oc[1] <= sync_oc[0];
			sync_open[0] <= OPEN_DETECT_I;
			sync_open[1] <= sync_open[0];
			sync_pulse[0] <= PULSE_INPUT_N_I;
			sync_pulse[1] <= sync_pulse[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Thermal flag: set wins over clear
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			thermal_shutdown_indicator <= 1'b0;
		else if (sync_temp[1])
			thermal_shutdown_indicator <= 1'b1;
		else if (CMD_I.clear_all_faults_cmd || CMD_I.clear_thermal_cmd)
			thermal_shutdown_indicator <= 1'b0;
	end

	// Power-on indicator, cleared by its command
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			power_on <= RST_POWER_ON;
		else if (CMD_I.clear_power_on_cmd || CMD_I.clear_all_faults_cmd)
			power_on <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Shared retry timer, one tick per period
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			retry_count <= 26'h0;
			retry_tick <= 1'b0;
		end
		else if (retry_count >= 26'(RETRY_CYCLES - 1))
		begin
			retry_count <= 26'h0;
			retry_tick <= 1'b1;
		end
		else
		begin
			retry_count <= retry_count + 26'h1;
			retry_tick <= 1'b0;
		end
	end

	assign deglitch_len = cfg[CFG_LONG_DEGLITCH] ?
		12'(DGL_LONG_CYC) : 12'(DGL_SHORT_CYC);

	// Over-current deglitch counters and latched flags
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			oc_flag <= RST_BYTE;
			for (int i = 0; i < 8; i++)
				oc_count[i] <= 12'h0;
		end
		else
		begin
			for (int i = 0; i < 8; i++)
			begin
				if (sync_oc[1][i] && CHANNEL_DRIVE_O[i]
					&& !CTRL_I.overcurrent_mask_bit[i])
				begin
					if (oc_count[i] >= deglitch_len - 12'h1)
						oc_flag[i] <= 1'b1;
					else
						oc_count[i] <= oc_count[i] + 12'h1;
				end
				else
				begin
					oc_count[i] <= 12'h0;
					if (CTRL_I.overcurrent_mask_bit[i]
						|| CMD_I.clear_all_faults_cmd)
						oc_flag[i] <= 1'b0;
					else if (cfg[CFG_RETRY] && retry_tick)
						oc_flag[i] <= 1'b0;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Open-load flags latch detection on an off channel unless masked
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			channel_open_indicator <= RST_BYTE;
		else
		begin
			for (int i = 0; i < 8; i++)
			begin
				if (CTRL_I.open_mask_bit[i])
					channel_open_indicator[i] <= 1'b0;
				else if (sync_open[1][i] && !CHANNEL_DRIVE_O[i])
					channel_open_indicator[i] <= 1'b1;
				else if (CMD_I.clear_all_faults_cmd)
					channel_open_indicator[i] <= 1'b0;
			end
		end
	end

	assign any_overcurrent_indicator = |oc_flag;
	assign any_open = |channel_open_indicator;
	assign fault_now = any_overcurrent_indicator | any_open
		| thermal_shutdown_indicator
		| (FRAME_ERROR_I & cfg[CFG_FRAME_CHECK]);

	// Summary fault memory; surviving causes show at read
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			fault_latched <= RST_FAULT;
		else if (CMD_I.clear_all_faults_cmd)
			fault_latched <= 1'b0;
		else if (fault_now)
			fault_latched <= 1'b1;
	end

	////////////////////////////////////////////////////////////////////////
	// Pulse input mapping, inputs active low
	always_comb
	begin
		pulse_map = RST_BYTE;
		for (int i = 0; i < 8; i++)
		begin
			if (cfg[CFG_PAIRING])
				pulse_map[i] = !sync_pulse[1][i / 2];
			else if (i < 4)
				pulse_map[i] = !sync_pulse[1][i];
		end
	end

	// Drive: commanded or pulsed, off under over-current or heat
	always_comb
	begin
		next_drive = (CTRL_I.channel_on_bit | pulse_map) & ~oc_flag;
		if (thermal_shutdown_indicator && sync_temp[1])
			next_drive = RST_BYTE;
		else if (sync_temp[1])
			next_drive = RST_BYTE;
		// Cooled die releases the outputs by itself
	end

	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			CHANNEL_DRIVE_O <= RST_BYTE;
		else
			CHANNEL_DRIVE_O <= next_drive;
	end

	// Open-drain alarm: low on fault or forced
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
		begin
			FAULT_ALARM_OUT_N_O <= 1'b0;
			FAULT_ALARM_OE_O <= 1'b0;
		end
		else
		begin
			FAULT_ALARM_OUT_N_O <= 1'b0;
			FAULT_ALARM_OE_O <= fault_now || cfg[CFG_FORCE_FAULT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read decode; there is no write path into this bank
	always_comb
	begin
		rd_byte = RST_BYTE;
		if (RD_ADDR_I == OFS_CHANNEL_ON)
			rd_byte = CTRL_I.channel_on_bit;
		else if (RD_ADDR_I == OFS_OC_MASK)
			rd_byte = CTRL_I.overcurrent_mask_bit;
		else if (RD_ADDR_I == OFS_OPEN_MASK)
			rd_byte = CTRL_I.open_mask_bit;
		else if (RD_ADDR_I == OFS_CONFIG)
			rd_byte = cfg;
		else if (RD_ADDR_I == OFS_STATUS)
		begin
			rd_byte[ST_POWER_ON] = power_on;
			rd_byte[ST_LOCK] = WRITE_LOCK_I;
			rd_byte[ST_THERMAL] = thermal_shutdown_indicator;
			rd_byte[ST_ANY_OC] = any_overcurrent_indicator;
			rd_byte[ST_ANY_OPEN] = any_open;
			rd_byte[ST_FRAME_ERR] = FRAME_ERROR_I;
			rd_byte[ST_FAULT] = fault_latched | fault_now;
		end
		else if (RD_ADDR_I == OFS_OPEN_FLAGS)
			rd_byte = channel_open_indicator;
	end

	// Read data register, holds between reads
	always_ff @(posedge CLK_I or negedge RESETN_I)
	begin
		if (!RESETN_I)
			RD_DATA_O <= RST_BYTE;
		else if (RD_EN_I)
			RD_DATA_O <= rd_byte;
	end

endmodule : dsr_bank
`default_nettype wire

/* File: testbench/dsr_bank_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dsr_bank_chk
	import dsr_pkg::*;
(
	input wire logic CLK_I,
	input wire logic RESETN_I,
	input wire dsr_ctrl_t CTRL_I,
	input wire logic WRITE_LOCK_I,
	input wire logic FRAME_ERROR_I,
	input wire logic [2:0] RD_ADDR_I,
	input wire logic RD_EN_I,
	input wire logic OVER_TEMP_I,
	input wire logic [7:0] RD_DATA_O,
	input wire logic [7:0] CHANNEL_DRIVE_O,
	input wire logic FAULT_ALARM_OUT_N_O,
	input wire logic FAULT_ALARM_OE_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!RESETN_I);
	// Read request at one offset
	sequence s_rd(logic [2:0] a);
		RD_EN_I && RD_ADDR_I == a;
	endsequence
	// Heat held long enough to pass the synchroniser
	sequence s_hot;
		OVER_TEMP_I [*4];
	endsequence
	chk_chan_readback: assert property (
		s_rd(OFS_CHANNEL_ON) |=> RD_DATA_O == $past(CTRL_I.channel_on_bit))
		else $error("channel on readback wrong");
	chk_ocmask_readback: assert property (
		s_rd(OFS_OC_MASK) |=> RD_DATA_O == $past(CTRL_I.overcurrent_mask_bit))
		else $error("over-current mask readback wrong");
	chk_openmask_readback: assert property (
		s_rd(OFS_OPEN_MASK) |=> RD_DATA_O == $past(CTRL_I.open_mask_bit))
		else $error("open mask readback wrong");
	chk_config_readback: assert property (
		s_rd(OFS_CONFIG) |=> RD_DATA_O == ($past(CTRL_I.config_bits) & 8'hF8))
		else $error("config readback wrong");
	chk_lock_bit: assert property (
		s_rd(OFS_STATUS) |=> RD_DATA_O[1] == $past(WRITE_LOCK_I))
		else $error("lock status bit wrong");
	chk_frame_err_bit: assert property (
		s_rd(OFS_STATUS) |=> RD_DATA_O[6] == $past(FRAME_ERROR_I) && !RD_DATA_O[3])
		else $error("frame error status bit wrong");
	chk_data_holds: assert property (
		!RD_EN_I |=> $stable(RD_DATA_O))
		else $error("read data changed without read");
	chk_unmapped_zero: assert property (
		(s_rd(3'h6) or s_rd(3'h7)) |=> RD_DATA_O == 8'h00)
		else $error("unmapped offset not zero");
	chk_hot_off: assert property (
		s_hot |-> CHANNEL_DRIVE_O == 8'h00)
		else $error("channels driven while hot");
	chk_force_alarm: assert property (
		CTRL_I.config_bits[7] [*2] |-> FAULT_ALARM_OE_O)
		else $error("forced alarm not pulled low");
	chk_alarm_level: assert property (
		FAULT_ALARM_OUT_N_O == 1'b0)
		else $error("alarm pin value not low");
	// Status read that shows a latched fault
	sequence s_fault_shown;
		s_rd(OFS_STATUS) ##1 (RD_DATA_O[5:4] != 2'h0 || RD_DATA_O[2]);
	endsequence
	chk_alarm_on_fault: assert property (
		s_fault_shown |-> FAULT_ALARM_OE_O)
		else $error("alarm not raised on fault");
endmodule : dsr_bank_chk
bind dsr_bank dsr_bank_chk u_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
	.CTRL_I(CTRL_I), .WRITE_LOCK_I(WRITE_LOCK_I),
	.FRAME_ERROR_I(FRAME_ERROR_I), .RD_ADDR_I(RD_ADDR_I), .RD_EN_I(RD_EN_I),
	.OVER_TEMP_I(OVER_TEMP_I), .RD_DATA_O(RD_DATA_O),
	.CHANNEL_DRIVE_O(CHANNEL_DRIVE_O),
	.FAULT_ALARM_OUT_N_O(FAULT_ALARM_OUT_N_O),
	.FAULT_ALARM_OE_O(FAULT_ALARM_OE_O));
`default_nettype wire

/* File: testbench/dsr_host.sv */
`timescale 1ns/1ps
`default_nettype none
module dsr_host
	import dsr_pkg::*;
(
	input wire logic clk_i,
	input wire logic [7:0] rd_data_i,
	output logic rd_en_o,
	output logic [2:0] rd_addr_o
);
	// Idle bus at start
	initial
	begin
		rd_en_o = 1'b0;
		rd_addr_o = 3'h0;
	end
	// One-byte read; address scrambled once released
	task automatic read(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_i);
		rd_en_o <= 1'b1;
		rd_addr_o <= a;
		@(posedge clk_i);
		rd_en_o <= 1'b0;
		rd_addr_o <= ~a;
		#1;
		d = rd_data_i;
	endtask : read
endmodule : dsr_host
`default_nettype wire

/* File: testbench/dsr_bank_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dsr_bank_tb
	import dsr_pkg::*;
;
	typedef struct packed {dsr_ctrl_t c; logic [2:0] a; logic [7:0] e;} dsr_row_t;
	logic clk, rst_n, lock, ferr, hot, rd_en, oe, out_n;
	dsr_ctrl_t ctrl;
	dsr_cmd_t cmd;
	logic [7:0] oc, opn, rdd, drv, d;
	logic [3:0] pls;
	logic [2:0] addr;
	int fails, n_tests;
	dsr_row_t rows [7] = '{'{32'hA53CC3FF, 3'h0, 8'hA5},
		'{32'hA53CC3FF, 3'h1, 8'h3C}, '{32'hA53CC3FF, 3'h2, 8'hC3},
		'{32'hA53CC3FF, 3'h3, 8'hF8}, '{32'hA53CC3FF, 3'h6, 8'h00},
		'{32'hA53CC3FF, 3'h7, 8'h00}, '{32'hA53CC300, 3'h3, 8'h00}};
	dsr_bank #(.RETRY_CYCLES(50)) dut (.CLK_I(clk), .RESETN_I(rst_n),
		.CTRL_I(ctrl), .CMD_I(cmd), .WRITE_LOCK_I(lock), .FRAME_ERROR_I(ferr),
		.RD_ADDR_I(addr), .RD_EN_I(rd_en), .OVER_TEMP_I(hot),
		.OVERCURRENT_I(oc), .OPEN_DETECT_I(opn), .PULSE_INPUT_N_I(pls),
		.RD_DATA_O(rdd), .CHANNEL_DRIVE_O(drv), .FAULT_ALARM_OUT_N_O(out_n),
		.FAULT_ALARM_OE_O(oe));
	dsr_host u_host (.clk_i(clk), .rd_data_i(rdd), .rd_en_o(rd_en),
		.rd_addr_o(addr));
	// Compare and count
	task check(input string n, input logic [7:0] s, input logic [7:0] e);
		n_tests++;
		if (s !== e)
		begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask : check
	// Verdict and end of run
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	// Small helpers for reads, waits and command pulses
	task rd(input logic [2:0] a);
		u_host.read(a, d);
	endtask : rd
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task pulse(input dsr_cmd_t c);
		@(posedge clk);
		cmd <= c;
		@(posedge clk);
		cmd <= '0;
	endtask : pulse
	// Clock
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Hang guard
	initial
	begin
		repeat (100000) @(posedge clk);
		fails++;
		report_and_stop();
	end
	// Main sequence
	initial
	begin
		{rst_n, lock, ferr, hot, ctrl, cmd, oc, opn} = '0;
		pls = 4'hF;
		fails = 0;
		n_tests = 0;
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		rd(OFS_STATUS);
		check("status reset", d, 8'h81);
		rd(OFS_CHANNEL_ON);
		check("channel reset", d, 8'h00);
		foreach (rows[i])
		begin
			@(posedge clk);
			ctrl <= rows[i].c;
			rd(rows[i].a);
			check("readback", d, rows[i].e);
		end
		@(posedge clk);
		{lock, ferr} <= 2'b11;
		rd(OFS_STATUS);
		check("lock and frame", d, 8'hC3);
		check("frame no alarm", {7'h00, oe}, 8'h00);
		@(posedge clk);
		{lock, ferr, ctrl} <= {2'b00, 32'hFF000000};
		cyc(5);
		check("drive cold", drv & 8'hF0, 8'hF0);
		@(posedge clk);
		hot <= 1'b1;
		cyc(5);
		check("drive hot", drv, 8'h00);
		pulse(3'b010);
		rd(OFS_STATUS);
		check("thermal held", d & 8'h04, 8'h04);
		@(posedge clk);
		hot <= 1'b0;
		cyc(6);
		check("drive cooled", drv & 8'hF0, 8'hF0);
		rd(OFS_STATUS);
		check("thermal kept", d & 8'h04, 8'h04);
		pulse(3'b010);
		rd(OFS_STATUS);
		check("thermal clear", d & 8'h04, 8'h00);
		@(posedge clk);
		hot <= 1'b1;
		cyc(5);
		@(posedge clk);
		hot <= 1'b0;
		cyc(5);
		pulse(3'b100);
		rd(OFS_STATUS);
		check("clear all", d, 8'h00);
		check("alarm idle", {7'h00, oe}, 8'h00);
		@(posedge clk);
		oc <= 8'h80;
		cyc(900);
		check("oc drive off", drv & 8'h80, 8'h00);
		rd(OFS_STATUS);
		check("oc status", d & 8'h90, 8'h90);
		@(posedge clk);
		oc <= 8'h00;
		cyc(4);
		pulse(3'b100);
		rd(OFS_STATUS);
		check("oc cleared", d & 8'h90, 8'h00);
		@(posedge clk);
		{ctrl, opn} <= {32'h0, 8'h04};
		cyc(5);
		rd(OFS_OPEN_FLAGS);
		check("open flags", d, 8'h04);
		rd(OFS_STATUS);
		check("open status", d & 8'hA0, 8'hA0);
		check("alarm open", {7'h00, oe}, 8'h01);
		check("alarm level", {7'h00, out_n}, 8'h00);
		@(posedge clk);
		ctrl <= 32'h00000400;
		cyc(3);
		rd(OFS_OPEN_FLAGS);
		check("open masked", d, 8'h00);
		check("alarm masked", {7'h00, oe}, 8'h00);
		@(posedge clk);
		ctrl <= 32'h00000480;
		cyc(3);
		check("alarm forced", {7'h00, oe}, 8'h01);
		@(posedge clk);
		{ctrl, pls} <= {32'h00000420, 4'hE};
		cyc(4);
		check("pulse paired", drv, 8'h03);
		@(posedge clk);
		ctrl <= 32'h00000400;
		cyc(4);
		check("pulse single", drv, 8'h01);
		@(posedge clk);
		{ctrl, oc, pls} <= {32'h80000400, 8'h80, 4'hF};
		cyc(900);
		check("oc latched", drv, 8'h00);
		@(posedge clk);
		{ctrl, oc} <= {32'h80000410, 8'h00};
		cyc(60);
		check("oc retried", drv, 8'h80);
		@(posedge clk);
		{ctrl, oc} <= {32'h80000440, 8'h80};
		cyc(1000);
		check("long wait", drv, 8'h80);
		cyc(1600);
		check("long trip", drv, 8'h00);
		report_and_stop();
	end
endmodule : dsr_bank_tb
`default_nettype wire
